// [rtl/bridge_irq_pkg.sv]
// Constants, register map and carrier types for the bridge interrupt block
package bridge_irq_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned MBOX_COUNT = 16;
    localparam int unsigned INT_LINES = 4;

    // ------------------------------------------------------------------
    // Byte offsets in the configuration window
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PCI_STATUS = 8'h48;
    localparam logic [7:0] OFS_PCI_CONFIG = 8'h4C;
    localparam logic [7:0] OFS_LOCAL_STATUS = 8'h76;
    localparam logic [7:0] OFS_LOCAL_MASK = 8'h77;
    localparam logic [7:0] OFS_PCI_MBX_WR = 8'hD0;
    localparam logic [7:0] OFS_PCI_MBX_RD = 8'hD2;
    localparam logic [7:0] OFS_LOCAL_MBX_WR = 8'hD4;
    localparam logic [7:0] OFS_LOCAL_MBX_RD = 8'hD6;
    localparam logic [7:0] OFS_MBX_STATUS_WR = 8'hD8;
    localparam logic [7:0] OFS_MBX_STATUS_RD = 8'hDA;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned ST_MAILBOX_BIT = 31;
    localparam int unsigned ST_LOCAL_BIT = 30;
    localparam int unsigned ST_OUT_POST_BIT = 27;
    localparam int unsigned ST_DMA_CHANNEL_ONE_IRQ_BIT = 25;
    localparam int unsigned ST_DMA_CHANNEL_ZERO_IRQ_BIT = 24;
    localparam int unsigned CFG_MAILBOX_EN_BIT = 31;
    localparam int unsigned CFG_LOCAL_EN_BIT = 30;
    localparam int unsigned CFG_OUT_POST_EN_BIT = 27;
    localparam int unsigned CFG_DMA_CHANNEL_ONE_IRQ_EN_BIT = 25;
    localparam int unsigned CFG_DMA_CHANNEL_ZERO_IRQ_EN_BIT = 24;
    localparam int unsigned LM_MAILBOX_BIT = 7;
    localparam int unsigned LANE_BITS = 8;
    localparam int unsigned HALF_BITS = 16;

    // Routed status bits that exist (diagonal positions are not routes)
    localparam logic [15:0] ROUTE_MASK = 16'h7BDE;
    // Bits of the PCI status word that are not reserved
    localparam logic [31:0] PCI_STATUS_VALID = 32'hCB00_7BDE;
    // Reserved bit 26 of the configuration word is not stored
    localparam logic [31:0] CFG_WRITABLE = 32'hFBFF_FFFF;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] MBX_EN_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic pci_read_error;
        logic pci_write_error;
        logic pci_interrupt;
        logic parity_error;
        logic inbound_queue_write;
        logic dma_channel_one_irq;
        logic dma_channel_zero_irq;
    } local_events_t;

    typedef struct packed {
        logic [MBOX_COUNT-1:0] pci_wr;
        logic [MBOX_COUNT-1:0] pci_rd;
        logic [MBOX_COUNT-1:0] local_wr;
        logic [MBOX_COUNT-1:0] local_rd;
    } mbox_events_t;

endpackage

// [rtl/bridge_irq_status_mask.sv]
// Interrupt status, mask and mailbox enable logic of the bus bridge
`timescale 1ns/1ps
module bridge_irq_status_mask
    import bridge_irq_pkg::*;
#(
    parameter int unsigned MBOXES = MBOX_COUNT
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire cfg_req_t cfg_req_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_rvalid_out,
    input wire mbox_events_t mbox_ev_in,
    input wire local_events_t local_ev_in,
    input wire logic out_post_not_empty_in,
    input wire logic [INT_LINES-1:0] int_lines_in,
    output logic [INT_LINES-1:0] int_request_out,
    output logic pci_irq_out,
    output logic local_irq_out
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*LANE_BITS +: LANE_BITS] = {LANE_BITS{be[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input cfg_req_t r);
        return (old & ~lane_mask(r.be)) | (r.wdata & lane_mask(r.be));
    endfunction

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0] cfg_q;
    logic local_direct_q;
    logic [7:0] local_mask_q;
    logic [MBOXES-1:0] pci_mbx_wr_en_q;
    logic [MBOXES-1:0] pci_mbx_rd_en_q;
    logic [MBOXES-1:0] local_mbx_wr_en_q;
    logic [MBOXES-1:0] local_mbx_rd_en_q;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic pci_irq_q;
    logic local_irq_q;
    logic [INT_LINES-1:0] int_request_q;

    logic [31:0] wmask;
    logic wr_status;
    logic wr_config;
    logic wr_local;
    logic wr_pci_mbx;
    logic wr_local_mbx;
    logic wr_mbx_status;

    assign wmask = lane_mask(cfg_req_in.be);
    assign wr_status = cfg_req_in.wr && word_hit(cfg_req_in.addr, OFS_PCI_STATUS);
    assign wr_config = cfg_req_in.wr && word_hit(cfg_req_in.addr, OFS_PCI_CONFIG);
    assign wr_local = cfg_req_in.wr && word_hit(cfg_req_in.addr, OFS_LOCAL_MASK);
    assign wr_pci_mbx = cfg_req_in.wr && word_hit(cfg_req_in.addr, OFS_PCI_MBX_WR);
    assign wr_local_mbx = cfg_req_in.wr && word_hit(cfg_req_in.addr, OFS_LOCAL_MBX_WR);
    assign wr_mbx_status = cfg_req_in.wr && word_hit(cfg_req_in.addr, OFS_MBX_STATUS_WR);

    // ------------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_q <= CFG_RESET;
        end else if (wr_config) begin
            cfg_q <= merge(cfg_q, cfg_req_in) & CFG_WRITABLE;
        end
    end

    // Direct request from the local master; lane 3 carries bit 30
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            local_direct_q <= 1'b0;
        end else if (wr_status && wmask[ST_LOCAL_BIT]) begin
            local_direct_q <= cfg_req_in.wdata[ST_LOCAL_BIT];
        end
    end

    // Mask sits in lane 3 of the word that also holds the local status
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            local_mask_q <= MASK_RESET;
        end else if (wr_local && cfg_req_in.be[3]) begin
            local_mask_q <= cfg_req_in.wdata[3*LANE_BITS +: LANE_BITS];
        end
    end

    // Write-event enables in the low half, read-event enables in the high half
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pci_mbx_wr_en_q <= MBX_EN_RESET;
            pci_mbx_rd_en_q <= MBX_EN_RESET;
        end else if (wr_pci_mbx) begin
            {pci_mbx_rd_en_q, pci_mbx_wr_en_q} <= merge({pci_mbx_rd_en_q, pci_mbx_wr_en_q},
                                                         cfg_req_in);
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            local_mbx_wr_en_q <= MBX_EN_RESET;
            local_mbx_rd_en_q <= MBX_EN_RESET;
        end else if (wr_local_mbx) begin
            {local_mbx_rd_en_q, local_mbx_wr_en_q} <= merge({local_mbx_rd_en_q,
                                                             local_mbx_wr_en_q},
                                                            cfg_req_in);
        end
    end

    // ------------------------------------------------------------------
    // Mailbox request status
    // ------------------------------------------------------------------
    // Kept apart by origin so each side is interrupted only by the other
    logic [2*MBOXES-1:0] pci_origin;
    logic [2*MBOXES-1:0] local_origin;
    logic [2*MBOXES-1:0] mbx_clear;
    logic [MBOXES-1:0] mailbox_write_status;
    logic [MBOXES-1:0] mailbox_read_status;
    logic mailbox_pending;

    assign mbx_clear = wr_mbx_status ? (cfg_req_in.wdata & wmask) : '0;

    sticky_flags #(.WIDTH(2*MBOXES)) u_pci_origin (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in({mbox_ev_in.pci_rd & pci_mbx_rd_en_q,
                 mbox_ev_in.pci_wr & pci_mbx_wr_en_q}),
        .clr_in(mbx_clear),
        .flags_out(pci_origin)
    );

    sticky_flags #(.WIDTH(2*MBOXES)) u_local_origin (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in({mbox_ev_in.local_rd & local_mbx_rd_en_q,
                 mbox_ev_in.local_wr & local_mbx_wr_en_q}),
        .clr_in(mbx_clear),
        .flags_out(local_origin)
    );

    assign mailbox_write_status = pci_origin[MBOXES-1:0] | local_origin[MBOXES-1:0];
    assign mailbox_read_status = pci_origin[2*MBOXES-1:MBOXES]
                               | local_origin[2*MBOXES-1:MBOXES];
    // Drops only when both status halves are fully cleared
    assign mailbox_pending = |{mailbox_write_status, mailbox_read_status};

    // ------------------------------------------------------------------
    // INTA..INTD cross-routing
    // ------------------------------------------------------------------
    logic [INT_LINES*INT_LINES-1:0] route_set;
    logic [INT_LINES*INT_LINES-1:0] route_status;
    logic [INT_LINES-1:0] route_target;

    irq_route_matrix #(.LINES(INT_LINES)) u_route (
        .lines_in(int_lines_in),
        .enable_in(cfg_q[INT_LINES*INT_LINES-1:0] & ROUTE_MASK),
        .status_in(route_status),
        .set_out(route_set),
        .target_out(route_target)
    );

    sticky_flags #(.WIDTH(INT_LINES*INT_LINES)) u_route_status (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(route_set),
        .clr_in(wr_status ? (cfg_req_in.wdata[HALF_BITS-1:0] & wmask[HALF_BITS-1:0]
                             & ROUTE_MASK) : '0),
        .flags_out(route_status)
    );

    // ------------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------------
    logic [31:0] pci_status;
    logic [7:0] local_status;

    always_comb begin
        pci_status = '0;
        pci_status[ST_MAILBOX_BIT] = mailbox_pending;
        pci_status[ST_LOCAL_BIT] = local_direct_q;
        pci_status[ST_OUT_POST_BIT] = out_post_not_empty_in;
        pci_status[ST_DMA_CHANNEL_ONE_IRQ_BIT] = local_ev_in.dma_channel_one_irq;
        pci_status[ST_DMA_CHANNEL_ZERO_IRQ_BIT] = local_ev_in.dma_channel_zero_irq;
        pci_status[HALF_BITS-1:0] = route_status & ROUTE_MASK;
    end

    assign local_status = {mailbox_pending, local_ev_in};

    // ------------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------------
    logic local_mbx_term;
    logic local_event_term;
    logic pci_irq_d;
    logic local_irq_d;

    assign local_mbx_term = local_mask_q[LM_MAILBOX_BIT] & (|pci_origin);
    // Error, PCI forward, queue write and DMA enables share one gate
    assign local_event_term = |(local_ev_in & local_mask_q[LM_MAILBOX_BIT-1:0]);
    assign local_irq_d = local_mbx_term | local_event_term;
    assign pci_irq_d = (cfg_q[CFG_MAILBOX_EN_BIT] & (|local_origin))
                     | (cfg_q[CFG_LOCAL_EN_BIT] & local_direct_q)
                     | (cfg_q[CFG_OUT_POST_EN_BIT] & out_post_not_empty_in)
                     | (cfg_q[CFG_DMA_CHANNEL_ONE_IRQ_EN_BIT] & local_ev_in.dma_channel_one_irq)
                     | (cfg_q[CFG_DMA_CHANNEL_ZERO_IRQ_EN_BIT] & local_ev_in.dma_channel_zero_irq);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pci_irq_q <= 1'b0;
            local_irq_q <= 1'b0;
            int_request_q <= '0;
        end else begin
            pci_irq_q <= pci_irq_d;
            local_irq_q <= local_irq_d;
            int_request_q <= route_target;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // One cycle of latency; unmapped words read as zero
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cfg_req_in.rd;
            if (!cfg_req_in.rd) begin
                rdata_q <= '0;
            end else if (word_hit(cfg_req_in.addr, OFS_PCI_STATUS)) begin
                rdata_q <= pci_status;
            end else if (word_hit(cfg_req_in.addr, OFS_PCI_CONFIG)) begin
                rdata_q <= cfg_q;
            end else if (word_hit(cfg_req_in.addr, OFS_LOCAL_STATUS)) begin
                rdata_q <= {local_mask_q, local_status, 16'h0000};
            end else if (word_hit(cfg_req_in.addr, OFS_PCI_MBX_RD)) begin
                rdata_q <= {pci_mbx_rd_en_q, pci_mbx_wr_en_q};
            end else if (word_hit(cfg_req_in.addr, OFS_LOCAL_MBX_RD)) begin
                rdata_q <= {local_mbx_rd_en_q, local_mbx_wr_en_q};
            end else if (word_hit(cfg_req_in.addr, OFS_MBX_STATUS_RD)) begin
                rdata_q <= {mailbox_read_status, mailbox_write_status};
            end else begin
                rdata_q <= '0;
            end
        end
    end

    assign cfg_rdata_out = rdata_q;
    assign cfg_rvalid_out = rvalid_q;
    assign pci_irq_out = pci_irq_q;
    assign local_irq_out = local_irq_q;
    assign int_request_out = int_request_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    mbox_raise_a: assert property (
        (mbox_ev_in.local_wr[0] && local_mbx_wr_en_q[0]) |=> pci_status[ST_MAILBOX_BIT])
        else $error("mailbox event did not raise status bit 31");

    mbox_clear_a: assert property (
        (wr_mbx_status && cfg_req_in.be == 4'hF && cfg_req_in.wdata == 32'hFFFF_FFFF
         && mbox_ev_in == '0) |=> !mailbox_pending)
        else $error("full mailbox clear left status pending");

    direct_req_a: assert property (
        (wr_status && cfg_req_in.be[3]) |=>
        pci_status[ST_LOCAL_BIT] == $past(cfg_req_in.wdata[ST_LOCAL_BIT]))
        else $error("direct request bit does not follow write");

    post_dma_read_a: assert property (
        (cfg_req_in.rd && word_hit(cfg_req_in.addr, OFS_PCI_STATUS)) |=>
        cfg_rvalid_out && cfg_rdata_out[ST_OUT_POST_BIT] == $past(out_post_not_empty_in)
        && cfg_rdata_out[ST_DMA_CHANNEL_ONE_IRQ_BIT] == $past(local_ev_in.dma_channel_one_irq)
        && cfg_rdata_out[ST_DMA_CHANNEL_ZERO_IRQ_BIT] == $past(local_ev_in.dma_channel_zero_irq))
        else $error("status read of post or DMA bits wrong");

    route_d_a: assert property (
        (cfg_q[14] && int_lines_in[2]) |=> route_status[14] ##1 int_request_out[3])
        else $error("route C into D not recorded or not driven");

    route_gate_a: assert property (
        $rose(route_status[9]) |-> $past(cfg_q[9]) && $past(int_lines_in[1]))
        else $error("routed bit set without its enable");

    mbox_gate_a: assert property (
        (!local_mask_q[LM_MAILBOX_BIT] && !local_event_term) |=> !local_irq_out)
        else $error("mailbox reached local side while masked");

    local_event_a: assert property (
        (local_ev_in.parity_error && local_mask_q[3]) |=> local_irq_out)
        else $error("enabled parity error did not interrupt locally");

    pci_side_en_a: assert property (
        (mbox_ev_in.pci_rd[5] && pci_mbx_rd_en_q[5] && local_mask_q[LM_MAILBOX_BIT]
         && !cfg_req_in.wr) |-> ##2 local_irq_out)
        else $error("enabled PCI mailbox read gave no local interrupt");

    local_side_en_a: assert property (
        (mbox_ev_in.local_wr[3] && local_mbx_wr_en_q[3] && cfg_q[CFG_MAILBOX_EN_BIT]
         && !cfg_req_in.wr) |-> ##2 pci_irq_out)
        else $error("enabled local mailbox write gave no PCI interrupt");

    reserved_zero_a: assert property (
        (cfg_req_in.rd && word_hit(cfg_req_in.addr, OFS_PCI_STATUS)) |=>
        (cfg_rdata_out & ~PCI_STATUS_VALID) == 32'h0000_0000)
        else $error("reserved status bit read non-zero");

    local_pending_a: assert property (
        (cfg_req_in.rd && word_hit(cfg_req_in.addr, OFS_LOCAL_STATUS)) |=>
        cfg_rdata_out[2*LANE_BITS + LM_MAILBOX_BIT] == $past(mailbox_pending))
        else $error("local status bit 7 disagrees with mailbox status");

    mbox_to_pci_c: cover property (mbox_ev_in.local_wr[0] ##2 pci_irq_out);
    mbox_to_local_c: cover property (mbox_ev_in.pci_rd != '0 ##2 local_irq_out);
    route_out_c: cover property (route_set != '0 ##2 int_request_out != '0);

endmodule // bridge_irq_status_mask

// [rtl/irq_route_matrix.sv]
// INTA..INTD cross-routing: set terms and per-output requests
`timescale 1ns/1ps
module irq_route_matrix #(
    parameter int unsigned LINES = 4
) (
    input wire logic [LINES-1:0] lines_in,
    input wire logic [LINES*LINES-1:0] enable_in,
    input wire logic [LINES*LINES-1:0] status_in,
    output logic [LINES*LINES-1:0] set_out,
    output logic [LINES-1:0] target_out
);
    // Bit b routes source b%LINES into target b/LINES; the diagonal is unused
    for (genvar b = 0; b < LINES*LINES; b++) begin : g_route
        if ((b % LINES) != (b / LINES)) begin : g_live
            assign set_out[b] = enable_in[b] & lines_in[b % LINES];
        end else begin : g_dead
            assign set_out[b] = 1'b0;
        end
    end

    for (genvar t = 0; t < LINES; t++) begin : g_target
        assign target_out[t] = |(status_in[t*LINES +: LINES] & ~(LINES'(1) << t));
    end
endmodule // irq_route_matrix

// [rtl/sticky_flags.sv]
// Sticky flag vector: hardware sets, software clears, set wins
`timescale 1ns/1ps
module sticky_flags #(
    parameter int unsigned WIDTH = 16
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] flags_out
);
    logic [WIDTH-1:0] flags_q;

    // An event in the clearing cycle survives the clear
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clr_in) | set_in;
        end
    end

    assign flags_out = flags_q;
endmodule // sticky_flags

// [sim/irq_far_side.sv]
// Far-side model: host and local master making mailbox accesses and lines
`timescale 1ns/1ps
module irq_far_side
    import bridge_irq_pkg::*;
(
    input wire logic mclk_in,
    output mbox_events_t mbox_ev_out,
    output local_events_t local_ev_out,
    output logic post_out,
    output logic [INT_LINES-1:0] lines_out
);
    initial begin
        mbox_ev_out = '0;
        local_ev_out = '0;
        post_out = 1'b0;
        lines_out = '0;
    end

    // Kind 0..3 = host write, host read, local write, local read of mailbox n
    // Strobes last one cycle and fall back to idle low
    task automatic access(input int kind, input int n);
        @(posedge mclk_in);
        #1;
        mbox_ev_out = mbox_events_t'(64'h1 << (n + 16 * (3 - kind)));
        @(posedge mclk_in);
        #1;
        mbox_ev_out = '0;
    endtask

    task automatic levels(input logic [6:0] ev, input logic post, input logic [3:0] ln);
        @(posedge mclk_in);
        #1;
        local_ev_out = ev;
        post_out = post;
        lines_out = ln;
    endtask
endmodule // irq_far_side

// [sim/tb_bridge_interrupt_status_mask.sv]
// Self-checking bench for the bridge interrupt status and mask block
`timescale 1ns/1ps
module tb_bridge_interrupt_status_mask
    import bridge_irq_pkg::*;
;
    logic mclk_in, rst_in, rvalid, pci_irq, local_irq, post, postw;
    logic [31:0] rdata, r, cfg, exp;
    logic [15:0] en;
    logic [7:0] mask;
    logic [6:0] lev;
    logic [3:0] int_req, ln, lines;
    cfg_req_t req;
    mbox_events_t mev;
    local_events_t levw;
    int err_total, n_checks, seed, n;
    int picks[3] = '{0, 5, 3};
    logic [7:0] offs[6] = '{8'h48, 8'h4C, 8'h74, 8'hD0, 8'hD4, 8'hD8};

    bridge_irq_status_mask DUT (.mclk_in(mclk_in), .rst_in(rst_in), .cfg_req_in(req),
        .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .mbox_ev_in(mev), .local_ev_in(levw),
        .out_post_not_empty_in(postw), .int_lines_in(lines), .int_request_out(int_req),
        .pci_irq_out(pci_irq), .local_irq_out(local_irq));
    irq_far_side far (.mclk_in(mclk_in), .mbox_ev_out(mev), .local_ev_out(levw),
        .post_out(postw), .lines_out(lines));

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    // ------------------------------------------------------------------
    // Bus tasks and model
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk_in);
        #1;
        req.addr = a;
        req.be = be;
        req.wdata = d;
        req.wr = 1'b1;
        @(posedge mclk_in);
        #1;
        req.wr = 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        #1;
        req.addr = a;
        req.rd = 1'b1;
        @(posedge mclk_in);
        #1;
        req.rd = 1'b0;
        chk(32'(rvalid), 32'h1);
        chk(rdata, e);
    endtask

    function automatic logic [31:0] st(logic mb, logic b30, logic [15:0] rt);
        return {mb, b30, 2'b0, post, 1'b0, lev[1:0], 8'h0, rt};
    endfunction

    task automatic final_report;
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        final_report;
    end

    initial begin
        seed = 26479;
        err_total = 0;
        n_checks = 0;
        req = '0;
        lev = '0;
        post = 1'b0;
        rst_in = 1'b1;
        repeat (3) @(posedge mclk_in);
        #1;
        rst_in = 1'b0;
        foreach (offs[i]) rc(offs[i], 32'h0);
        // Levels, direct request, masks and enables with random data
        repeat (6) begin
            r = $random(seed);
            lev = r[6:0];
            post = r[7];
            mask = r[15:8];
            cfg = r & 32'hFB00_0000;
            far.levels(lev, post, 4'h0);
            bus_wr(8'h4C, 4'hF, cfg);
            bus_wr(8'h48, 4'hF, ~r);
            rc(8'h48, st(1'b0, ~r[30], 16'h0));
            exp = 32'((cfg[30] & ~r[30]) | (cfg[27] & post) | (cfg[25] & lev[1])
                | (cfg[24] & lev[0]));
            chk(32'(pci_irq), exp);
            bus_wr(8'h74, 4'h8, {mask, 24'h0});
            rc(8'h74, {mask, 1'b0, lev, 16'h0});
            chk(32'(local_irq), 32'(|(lev & mask[6:0])));
            bus_wr(8'hD0, 4'hF, ~r);
            rc(8'hD0, ~r);
            bus_wr(8'hD4, 4'hF, r);
            rc(8'hD4, r);
        end
        // Mailbox events: only enabled accesses latch, W1C by halves
        lev = '0;
        post = 1'b0;
        far.levels(7'h0, 1'b0, 4'h0);
        bus_wr(8'h48, 4'h8, 32'h0);
        bus_wr(8'h4C, 4'hF, 32'h8000_0000);
        for (int k = 0; k < 4; k++) begin
            // Fixed mailboxes first so each mailbox assertion is exercised
            n = (k < 3) ? picks[k] : int'($unsigned($random(seed)) % 16);
            mask = {k[0], 7'h0};
            bus_wr(8'h74, 4'h8, {mask, 24'h0});
            bus_wr(8'hD0, 4'hF, 32'h1 << (16 + n));
            bus_wr(8'hD4, 4'hF, 32'h1 << n);
            for (int kind = 3; kind >= 0; kind--) far.access(kind, n);
            chk(32'(pci_irq), 32'h1);
            chk(32'(local_irq), 32'(k[0]));
            rc(8'hD8, 32'h0001_0001 << n);
            rc(8'h74, {mask, 8'h80, 16'h0});
            bus_wr(8'hD8, 4'h3, 32'h1 << n);
            rc(8'h48, st(1'b1, 1'b0, 16'h0));
            bus_wr(8'hD8, 4'hC, 32'h1 << (16 + n));
            rc(8'h48, st(1'b0, 1'b0, 16'h0));
            chk(32'({pci_irq, local_irq}), 32'h0);
        end
        // A full-word clear drops a pending read status at once
        far.access(1, n);
        bus_wr(8'hD8, 4'hF, 32'hFFFF_FFFF);
        rc(8'hD8, 32'h0);
        chk(32'(local_irq), 32'h0);
        // Line cross-routing with random enables and lines
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            // First pass forces the C-into-D and B-into-C routes on
            en = (r[15:0] | (k == 0 ? 16'h4200 : 16'h0000)) & ROUTE_MASK;
            ln = r[19:16] | (k == 0 ? 4'h6 : 4'h0);
            bus_wr(8'h4C, 4'hF, {16'h0, en});
            far.levels(7'h0, 1'b0, ln);
            far.levels(7'h0, 1'b0, 4'h0);
            exp = '0;
            for (int b = 0; b < 16; b++) exp[b] = en[b] & ln[b % 4];
            rc(8'h48, exp);
            chk(32'(int_req), 32'({|exp[15:12], |exp[11:8], |exp[7:4], |exp[3:0]}));
            bus_wr(8'h48, 4'h3, 32'h0000_FFFF);
            rc(8'h48, 32'h0);
        end
        final_report;
    end
endmodule // tb_bridge_interrupt_status_mask
